// ---- src/tbc_defines.svh ----
// Constants of the time base counter: SFR offsets, counter layout, tap bits
// and reset values. Definitions only; included by the counter core and the test files.
`ifndef TBC_DEFINES_SVH
`define TBC_DEFINES_SVH

// SFR address width and the three count register offsets
`define TBC_ADDR_W        8
`define TBC_OFS_LOW       8'h60
`define TBC_OFS_MID       8'h61
`define TBC_OFS_HIGH      8'h62

// Counter stages are numbered 1..15; stage n runs at tick/2^n
`define TBC_CNT_LSB       1
`define TBC_CNT_MSB       15
`define TBC_CNT_RST       15'h0000
`define TBC_CNT_ONE       15'h0001

// Stages kept by a clearing write: mid keeps 1..7, high keeps 1..11
`define TBC_KEEP_MID      15'h007f
`define TBC_KEEP_HIGH     15'h07ff

// Nibble windows seen through the count registers
`define TBC_LOW_LSB       4
`define TBC_MID_LSB       8
`define TBC_HIGH_LSB      12

// Interrupt taps (32 Hz, 16 Hz, 4 Hz, 2 Hz with a 32.768 kHz tick)
`define TBC_TAP_32HZ      10
`define TBC_TAP_16HZ      11
`define TBC_TAP_4HZ       13
`define TBC_TAP_2HZ       14

// Interrupt flag positions in the group 2 request field
`define TBC_IRQ_32HZ      3
`define TBC_IRQ_16HZ      2
`define TBC_IRQ_4HZ       1
`define TBC_IRQ_2HZ       0

// Reset values of flags and read data
`define TBC_FLAG_RST      4'h0
`define TBC_NIB_RST       4'h0

`endif

// ---- src/tbc_fall_detect.sv ----
// Falling edge detector for a level that is synchronous to core_clk.
// Assumes the level input is already clean and synchronous.
`timescale 1ns/1ps
module tbc_fall_detect (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Level in, one-cycle pulse out
    input  wire logic level,
    output logic      fall
);

    tbc_pkg::tbc_fall_state_t st_r;   // Registered state
    tbc_pkg::tbc_fall_state_t st_nxt; // Next state

    // Next state: remember the level
    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = level;
    end

    // State register; prev starts low so a low level at reset is no edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r.prev <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pulse when the level drops
    assign fall = st_r.prev & ~level;

endmodule

// ---- src/tbc_pkg.sv ----
// Types shared by the time base counter modules.
// Assumes nothing beyond the constants header.
package tbc_pkg;

    // Whole state of the counter core
    typedef struct packed {
        logic [15:1] cnt;     // Counter stages 1..15
        logic [3:0]  flags;   // Interrupt request flags, group 2
        logic [3:0]  rdata;   // Registered SFR read data
    } tbc_state_t;

    // State of the falling edge detector
    typedef struct packed {
        logic prev;           // Level seen on the previous clock
    } tbc_fall_state_t;

endpackage

// ---- src/tbc_time_base_counter.sv ----
// Time base counter: 15-stage up-counter stepped by the low-speed tick
// clock, three 4-bit count registers that read and clear it, and four
// interrupt taps.
// Assumes SFR strobes and the tick level are synchronous to core_clk and
// that the tick runs far slower than core_clk.
//
// Overview of operation
// - Fifteen-stage counter, stages offered as clock taps
// - Steps on tick falling edge, from reset
// - System reset clears whole counter
// - Count registers read bits 4-7, 8-11, 12-15
// - Write to low register clears bits 1-15
// - Write to middle register clears bits 8-15
// - Write to high register clears bits 12-15
// - Clear ignores written data value
// - Falling taps 10,11,13,14 set flags 3..0
// - Taps give 32, 16, 4, 2 Hz
// - Clear-caused tap fall also raises request
// - Counter stages drive other circuits as clocks
`timescale 1ns/1ps
`include "tbc_defines.svh"
module tbc_time_base_counter (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    // Low-speed tick clock, sampled as a level
    input  wire logic                   low_speed_tick_clock,
    // SFR access port
    input  wire logic [`TBC_ADDR_W-1:0] sfr_addr,
    input  wire logic                   sfr_wr,
    input  wire logic [3:0]             sfr_wdata,
    input  wire logic                   sfr_rd,
    output logic      [3:0]             sfr_rdata,
    // Interrupt request flags, group 2
    input  wire logic [3:0]             irq_clear,
    output logic      [3:0]             interrupt_request_group2,
    // Counter stages for other circuits
    output logic      [15:1]            count_taps,
    output logic                        tap_32hz,
    output logic                        tap_16hz,
    output logic                        tap_4hz,
    output logic                        tap_2hz
);

    tbc_pkg::tbc_state_t st_r;    // Registered state
    tbc_pkg::tbc_state_t st_nxt;  // Next state
    logic                tick_fall; // Tick clock falling edge pulse
    logic [15:1]         keep_mask; // Stages surviving this cycle's write
    logic [15:1]         stepped;   // Counter after the optional step

    // Which stages a write to the given address leaves alone
    function automatic logic [15:1] keep_for(input logic [`TBC_ADDR_W-1:0] a,
                                              input logic             wr);
        logic [15:1] m;
        m = '1;
        if (wr) begin
            case (a)
                `TBC_OFS_LOW:  m = '0;
                `TBC_OFS_MID:  m = `TBC_KEEP_MID;
                `TBC_OFS_HIGH: m = `TBC_KEEP_HIGH;
                default:       m = '1;
            endcase
        end
        return m;
    endfunction

    // Nibble shown by the given address, zero when unmapped
    function automatic logic [3:0] nib_for(input logic [`TBC_ADDR_W-1:0] a,
                                           input logic [15:1]        c);
        logic [3:0] n;
        n = `TBC_NIB_RST;
        case (a)
            `TBC_OFS_LOW:  n = c[`TBC_LOW_LSB+3:`TBC_LOW_LSB];
            `TBC_OFS_MID:  n = c[`TBC_MID_LSB+3:`TBC_MID_LSB];
            `TBC_OFS_HIGH: n = c[`TBC_HIGH_LSB+3:`TBC_HIGH_LSB];
            default:       n = `TBC_NIB_RST;
        endcase
        return n;
    endfunction

    // Falling edge of the tick clock
    tbc_fall_detect u_tick_fall (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .level    (low_speed_tick_clock),
        .fall     (tick_fall)
    );

    // Next state of counter, flags and read data
    always_comb begin
        st_nxt = st_r;
        // Step on tick fall; all-ones rolls over to zero
        stepped = tick_fall ? 15'(st_r.cnt + `TBC_CNT_ONE) : st_r.cnt;
        // Write strobe and address pick the clear, data is never looked at
        keep_mask = keep_for(sfr_addr, sfr_wr);
        // Clear applied after the step so it wins on cleared stages
        st_nxt.cnt = stepped & keep_mask;
        // Flags: clear first, then any tap fall sets (set wins)
        st_nxt.flags = st_r.flags & ~irq_clear;
        // Tap falls from stepping or from clearing both count
        st_nxt.flags[`TBC_IRQ_32HZ] = st_nxt.flags[`TBC_IRQ_32HZ]
            | (st_r.cnt[`TBC_TAP_32HZ] & ~st_nxt.cnt[`TBC_TAP_32HZ]);
        st_nxt.flags[`TBC_IRQ_16HZ] = st_nxt.flags[`TBC_IRQ_16HZ]
            | (st_r.cnt[`TBC_TAP_16HZ] & ~st_nxt.cnt[`TBC_TAP_16HZ]);
        st_nxt.flags[`TBC_IRQ_4HZ] = st_nxt.flags[`TBC_IRQ_4HZ]
            | (st_r.cnt[`TBC_TAP_4HZ] & ~st_nxt.cnt[`TBC_TAP_4HZ]);
        st_nxt.flags[`TBC_IRQ_2HZ] = st_nxt.flags[`TBC_IRQ_2HZ]
            | (st_r.cnt[`TBC_TAP_2HZ] & ~st_nxt.cnt[`TBC_TAP_2HZ]);
        // Read data: nibble of the current count, zero when idle
        st_nxt.rdata = sfr_rd ? nib_for(sfr_addr, st_r.cnt) : `TBC_NIB_RST;
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r.cnt   <= `TBC_CNT_RST;
            st_r.flags <= `TBC_FLAG_RST;
            st_r.rdata <= `TBC_NIB_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign sfr_rdata                = st_r.rdata;
    assign interrupt_request_group2 = st_r.flags;
    // Stages as clocks for other circuits
    assign count_taps = st_r.cnt;
    // Stage n runs at tick/2^n, so these give 32/16/4/2 Hz
    assign tap_32hz   = st_r.cnt[`TBC_TAP_32HZ];
    assign tap_16hz   = st_r.cnt[`TBC_TAP_16HZ];
    assign tap_4hz    = st_r.cnt[`TBC_TAP_4HZ];
    assign tap_2hz    = st_r.cnt[`TBC_TAP_2HZ];

    // Checks on the counter and flags

    a_low_clear_all: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_wr && sfr_addr == `TBC_OFS_LOW) |=> (count_taps == `TBC_CNT_RST))
        else $error("low register write did not clear counter");

    a_mid_clear_upper: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_wr && sfr_addr == `TBC_OFS_MID) |=>
            (count_taps[15:8] == 8'h00
             && count_taps[7:1] == $past(stepped[7:1])))
        else $error("middle register write cleared wrong stages");

    a_high_clear_top: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_wr && sfr_addr == `TBC_OFS_HIGH) |=>
            (count_taps[15:12] == 4'h0
             && count_taps[11:1] == $past(stepped[11:1])))
        else $error("high register write cleared wrong stages");

    a_count_step: assert property (@(posedge core_clk) disable iff (!arst_n)
        (tick_fall && !sfr_wr) |=> (count_taps == 15'($past(count_taps) + 15'h0001)))
        else $error("counter did not step on tick fall");

    a_count_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!tick_fall && !sfr_wr) |=> $stable(count_taps))
        else $error("counter moved without tick or write");

    a_wrap_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        (count_taps == 15'h7fff && tick_fall && !sfr_wr) |=> (count_taps == 15'h0000))
        else $error("counter did not wrap to zero");

    a_read_nibble: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_rd && sfr_addr == `TBC_OFS_MID) |=> (sfr_rdata == $past(count_taps[11:8])))
        else $error("middle register read wrong nibble");

    a_read_high: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_rd && sfr_addr == `TBC_OFS_HIGH) |=> (sfr_rdata == $past(count_taps[15:12])))
        else $error("high register read wrong nibble");

    a_irq_on_fall: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(tap_32hz) |-> interrupt_request_group2[3])
        else $error("32 Hz tap fall did not set its flag");

    a_irq_clear_fall: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_wr && sfr_addr == `TBC_OFS_HIGH && tap_2hz) |=> interrupt_request_group2[0])
        else $error("clear of 2 Hz tap did not set its flag");

    c_tick_step: cover property (@(posedge core_clk) disable iff (!arst_n)
        tick_fall ##2 tick_fall);
    c_wrap: cover property (@(posedge core_clk) disable iff (!arst_n)
        count_taps == 15'h7fff ##1 count_taps == 15'h0000);
    c_clear_irq: cover property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_wr && sfr_addr == `TBC_OFS_MID && tap_32hz));
    c_read_low: cover property (@(posedge core_clk) disable iff (!arst_n)
        (sfr_rd && sfr_addr == `TBC_OFS_LOW && count_taps[7:4] != 4'h0));

endmodule

// ---- test/tbc_cpu_model.sv ----
// CPU side model: issues SFR reads and writes and clears request flags.
// Assumes the block samples every strobe on the rising edge of core_clk.
`timescale 1ns/1ps
`include "tbc_defines.svh"
module tbc_cpu_model (
    // Clock
    input  wire logic                   core_clk,
    // SFR access port
    output logic [`TBC_ADDR_W-1:0]      sfr_addr,
    output logic                        sfr_wr,
    output logic [3:0]                  sfr_wdata,
    output logic                        sfr_rd,
    input  wire logic [3:0]             sfr_rdata,
    // Request flag clear
    output logic [3:0]                  irq_clear
);
    // Idle bus at time zero
    initial begin
        sfr_addr  = 8'h00;
        sfr_wr    = 1'b0;
        sfr_wdata = 4'h0;
        sfr_rd    = 1'b0;
        irq_clear = 4'h0;
    end

    // One write strobe; released lines show inverted values
    task automatic sfr_write(input logic [7:0] a, input logic [3:0] d);
        @(posedge core_clk);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_wr    <= 1'b0;
        sfr_addr  <= ~a;
        sfr_wdata <= ~d;
    endtask

    // One read strobe; data is taken one cycle after the strobe edge
    task automatic sfr_read(input logic [7:0] a, output logic [3:0] d);
        @(posedge core_clk);
        sfr_rd   <= 1'b1;
        sfr_addr <= a;
        @(posedge core_clk);
        sfr_rd   <= 1'b0;
        sfr_addr <= ~a;
        #1;
        d = sfr_rdata;
    endtask

    // Clear request flags after software has masked them
    task automatic clear_flags(input logic [3:0] m);
        @(posedge core_clk);
        irq_clear <= m;
        @(posedge core_clk);
        irq_clear <= 4'h0;
    endtask
endmodule

// ---- test/time_base_counter_test.sv ----
// Self-checking bench for the time base counter.
// Assumes the tick level is made here, synchronous to core_clk.
`timescale 1ns/1ps
`include "tbc_defines.svh"
module time_base_counter_test;
    logic                   core_clk;  // 125 MHz system clock
    logic                   arst_n;    // Async reset, active low
    logic                   tick;      // Low-speed tick level
    logic [`TBC_ADDR_W-1:0] sfr_addr;  // SFR address
    logic                   sfr_wr;    // Write strobe
    logic [3:0]             sfr_wdata; // Write data
    logic                   sfr_rd;    // Read strobe
    logic [3:0]             sfr_rdata; // Read data
    logic [3:0]             irq_clear; // Flag clear
    logic [3:0]             flags;     // Request flags
    logic [15:1]            taps;      // Counter stages
    logic [3:0]             tap4;      // Interrupt taps, flag order
    logic [15:1]            exp_cnt;   // Expected count
    logic [3:0]             exp_flg;   // Expected flags
    logic [3:0]             rd;        // Read result
    int                     error_cnt;
    int                     check_count;

    tbc_time_base_counter tbc_time_base_counter_i (.core_clk(core_clk), .arst_n(arst_n),
        .low_speed_tick_clock(tick), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .irq_clear(irq_clear), .interrupt_request_group2(flags), .count_taps(taps),
        .tap_32hz(tap4[3]), .tap_16hz(tap4[2]), .tap_4hz(tap4[1]), .tap_2hz(tap4[0]));
    tbc_cpu_model tbc_cpu_model_i (.core_clk(core_clk), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .irq_clear(irq_clear));

    // Clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Verdict and end of run
    task automatic end_sim;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One comparison
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, want);
        end
    endtask

    // Model a new count; taps falling 1->0 set their flags
    task automatic upd(input logic [15:1] n);
        exp_flg |= {exp_cnt[10] & ~n[10], exp_cnt[11] & ~n[11],
                    exp_cnt[13] & ~n[13], exp_cnt[14] & ~n[14]};
        exp_cnt = n;
    endtask

    // One tick period: high then low
    task automatic step;
        @(posedge core_clk);
        tick <= 1'b1;
        @(posedge core_clk);
        tick <= 1'b0;
        upd(exp_cnt + 15'h0001);
    endtask

    // Let updates land, then compare count, taps and flags
    task automatic check_all;
        repeat (2) @(posedge core_clk);
        #1;
        check({1'b0, taps}, {1'b0, exp_cnt});
        check({12'h000, tap4}, {12'h000, exp_cnt[10], exp_cnt[11], exp_cnt[13],
              exp_cnt[14]});
        check({12'h000, flags}, {12'h000, exp_flg});
    endtask

    // Hang guard
    initial begin
        repeat (95000) @(posedge core_clk);
        error_cnt++;
        end_sim();
    end

    // Main sequence
    initial begin
        tick = 1'b0;
        arst_n = 1'b0;
        exp_cnt = 15'h0000;
        exp_flg = 4'h0;
        error_cnt = 0;
        check_count = 0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        check_all();
        for (int i = 0; i < 32767; i++) step();
        check_all();
        step();
        check_all();
        // Climb to 0x2600 so taps 10, 11 and 14 stand high for the clears
        for (int i = 0; i < 9728; i++) step();
        check_all();
        tbc_cpu_model_i.clear_flags(4'hf);
        exp_flg = 4'h0;
        for (int i = 0; i < 3; i++) begin
            tbc_cpu_model_i.sfr_read(8'h60 + i[7:0], rd);
            check({12'h000, rd}, {12'h000, exp_cnt[4 + 4 * i +: 4]});
        end
        tbc_cpu_model_i.sfr_read(8'h63, rd);
        check({12'h000, rd}, 16'h0000);
        tbc_cpu_model_i.sfr_write(8'h63, 4'h0);
        check_all();
        tbc_cpu_model_i.sfr_write(`TBC_OFS_HIGH, 4'h0);
        upd(exp_cnt & 15'h07ff);
        check_all();
        @(posedge core_clk);
        tick <= 1'b1;
        fork
            tbc_cpu_model_i.sfr_write(`TBC_OFS_MID, 4'hf);
            begin
                @(posedge core_clk);
                tick <= 1'b0;
            end
        join
        upd((exp_cnt + 15'h0001) & 15'h007f);
        check_all();
        tbc_cpu_model_i.sfr_write(`TBC_OFS_LOW, 4'ha);
        upd(15'h0000);
        check_all();
        end_sim();
    end
endmodule
